// [rtl/idst_pkg.sv]
package idst_pkg;

    // register byte addresses
    localparam logic [31:0] ADDR_DATA_CMD = 32'h5002_0310;
    localparam logic [31:0] ADDR_SS_HIGH = 32'h5002_0314;
    localparam logic [31:0] ADDR_SS_LOW = 32'h5002_0318;
    localparam logic [31:0] ADDR_FS_HIGH = 32'h5002_031C;
    localparam logic [31:0] ADDR_CTRL = 32'h5002_0340;
    localparam logic [31:0] ADDR_IRQ_STAT = 32'h5002_0344;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'h5002_0348;
    localparam logic [31:0] ADDR_STATUS = 32'h5002_034C;

    // reset values
    localparam logic [15:0] SS_HIGH_RST = 16'h0091;
    localparam logic [15:0] SS_LOW_RST = 16'h00AB;
    localparam logic [15:0] FS_HIGH_RST = 16'h001A;
    localparam logic [2:0] CTRL_RST = 3'h2;

    // smallest stored counts and idle margin
    localparam logic [15:0] HIGH_MIN = 16'h0006;
    localparam logic [15:0] LOW_MIN = 16'h0008;
    localparam logic [15:0] IDLE_MARGIN = 16'h000A;

    // data/command word fields
    localparam int CMD_READ_BIT = 8;
    localparam int CMD_STOP_BIT = 9;

    // control fields: enable, speed mode
    localparam int CTRL_EN_BIT = 0;
    localparam logic [1:0] SPEED_STD = 2'h1;
    localparam logic [1:0] SPEED_FAST = 2'h2;
    localparam logic [1:0] SPEED_HIGH = 2'h3;

    // interrupt status bits
    localparam int IRQ_ABORT = 0;
    localparam int IRQ_RX_DONE = 1;
    localparam int IRQ_STOP = 2;
    localparam int IRQ_W = 3;

    localparam logic [3:0] LAST_BIT = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_BIT = 3'b010,
        ST_STOP = 3'b011,
        ST_HOLD = 3'b100
    } idst_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } idst_apb_req_t;

endpackage

// [rtl/idst_phase_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module idst_phase_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic run,
    input wire logic start_low,
    input wire logic [15:0] hcnt,
    input wire logic [15:0] lcnt,
    output logic phase_high,
    output logic phase_end
);
    import idst_pkg::*;

    logic [15:0] cnt_reg, cnt_next;
    logic high_reg, high_next;
    logic [15:0] len;

    // each phase lasts exactly its count in pclk cycles
    assign len = high_reg ? hcnt : lcnt;
    assign phase_end = run && (cnt_reg == len - 16'h0001);
    assign phase_high = high_reg;

    always_comb begin
        cnt_next = cnt_reg;
        high_next = high_reg;
        if (!run) begin
            cnt_next = 16'h0000;
            high_next = !start_low;
        end else if (phase_end) begin
            cnt_next = 16'h0000;
            high_next = !high_reg;
        end else begin
            cnt_next = cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 16'h0000;
            high_reg <= 1'b1;
        end else if (ce) begin
            cnt_reg <= cnt_next;
            high_reg <= high_next;
        end
    end

endmodule
`default_nettype wire

// [rtl/idst_top.sv]
// Overview of operation
// - read command after read request aborts
// - colliding read command discarded, abort raised
// - read command ignores its data byte
// - data register reads received byte
// - standard high count, reset 0x91
// - count writes only while disabled
// - high counts below 6 store 6
// - standard low count below 8 stores 8
// - idle when counter reaches high plus 10
// - standard low count, reset 0xAB
// - fast high count, reset 0x1A
// - high speed uses fast high count
// - command bit one reads, zero writes
// - stop after byte, else go on with a queued command or hold clock low
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module idst_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire idst_pkg::idst_apb_req_t apb_req,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic irq,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic rd_req_raise,
    input wire logic rd_req_served
);
    import idst_pkg::*;

    function automatic logic [15:0] clamp_min(input logic [15:0] v, input logic [15:0] lim);
        clamp_min = (v < lim) ? lim : v;
    endfunction

    function automatic logic addr_hit(input logic [31:0] a);
        addr_hit = (a == ADDR_DATA_CMD) || (a == ADDR_SS_HIGH) || (a == ADDR_SS_LOW) ||
            (a == ADDR_FS_HIGH) || (a == ADDR_CTRL) || (a == ADDR_IRQ_STAT) ||
            (a == ADDR_IRQ_MASK) || (a == ADDR_STATUS);
    endfunction

    // register group
    logic pready_reg, pready_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;
    logic irq_reg, irq_next;
    logic [15:0] ss_h_reg, ss_h_next, ss_l_reg, ss_l_next, fs_h_reg, fs_h_next;
    logic [2:0] ctrl_reg, ctrl_next;
    logic [IRQ_W-1:0] istat_reg, istat_next, imask_reg, imask_next;
    logic rd_pend_reg, rd_pend_next;
    logic cmd_valid_reg, cmd_valid_next, cmd_read_reg, cmd_read_next, cmd_stop_reg, cmd_stop_next;
    logic [7:0] cmd_byte_reg, cmd_byte_next, rx_byte_reg, rx_byte_next;
    // engine group
    idst_state_t state_reg, state_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic cur_read_reg, cur_read_next, cur_stop_reg, cur_stop_next;
    logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
    logic take, rx_evt, stop_evt;
    // line sampling group
    logic scl_s1_reg, scl_s2_reg, sda_s1_reg, sda_s2_reg;
    logic [15:0] idle_cnt_reg, idle_cnt_next;
    logic bus_idle_reg, bus_idle_next;

    logic rd_phase, wr_acc, dc_wr, enabled;
    logic [15:0] hcnt_sel, idle_limit;
    logic tm_high, tm_end, tm_run, tm_hold;

    assign rd_phase = apb_req.psel && apb_req.penable && !pready_reg;
    assign wr_acc = apb_req.psel && apb_req.penable && pready_reg && apb_req.pwrite;
    assign dc_wr = wr_acc && (apb_req.paddr == ADDR_DATA_CMD);
    assign enabled = ctrl_reg[CTRL_EN_BIT];
    assign idle_limit = ss_h_reg + IDLE_MARGIN;
    // fast high count serves every speed mode except standard, including high speed
    assign hcnt_sel = (ctrl_reg[2:1] == SPEED_STD) ? ss_h_reg : fs_h_reg;
    assign tm_run = (state_reg != ST_IDLE) && (state_reg != ST_HOLD);
    assign tm_hold = (state_reg == ST_HOLD);

    idst_phase_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .run(tm_run),
        .start_low(tm_hold),
        .hcnt(hcnt_sel),
        .lcnt(ss_l_reg),
        .phase_high(tm_high),
        .phase_end(tm_end)
    );

    always_comb begin
        pready_next = apb_req.psel && apb_req.penable && !pready_reg;
        pslverr_next = rd_phase && !addr_hit(apb_req.paddr);
        prdata_next = 32'h0000_0000;
        ss_h_next = ss_h_reg;
        ss_l_next = ss_l_reg;
        fs_h_next = fs_h_reg;
        ctrl_next = ctrl_reg;
        imask_next = imask_reg;
        istat_next = istat_reg;
        cmd_valid_next = cmd_valid_reg && !take;
        cmd_read_next = cmd_read_reg;
        cmd_stop_next = cmd_stop_reg;
        cmd_byte_next = cmd_byte_reg;
        rx_byte_next = rx_byte_reg;
        rd_pend_next = rd_pend_reg;
        if (rd_phase && !apb_req.pwrite) begin
            case (apb_req.paddr)
                ADDR_DATA_CMD: prdata_next = {24'h00_0000, rx_byte_reg};
                ADDR_SS_HIGH: prdata_next = {16'h0000, ss_h_reg};
                ADDR_SS_LOW: prdata_next = {16'h0000, ss_l_reg};
                ADDR_FS_HIGH: prdata_next = {16'h0000, fs_h_reg};
                ADDR_CTRL: prdata_next = {29'h0000_0000, ctrl_reg};
                ADDR_IRQ_STAT: prdata_next = {29'h0000_0000, istat_reg};
                ADDR_IRQ_MASK: prdata_next = {29'h0000_0000, imask_reg};
                ADDR_STATUS: prdata_next = {28'h000_0000, rd_pend_reg, tm_run, cmd_valid_reg, bus_idle_reg};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
        if (wr_acc) begin
            case (apb_req.paddr)
                ADDR_SS_HIGH: if (!enabled) ss_h_next = clamp_min(apb_req.pwdata[15:0], HIGH_MIN);
                ADDR_SS_LOW: if (!enabled) ss_l_next = clamp_min(apb_req.pwdata[15:0], LOW_MIN);
                ADDR_FS_HIGH: if (!enabled) fs_h_next = clamp_min(apb_req.pwdata[15:0], HIGH_MIN);
                ADDR_CTRL: ctrl_next = apb_req.pwdata[2:0];
                ADDR_IRQ_STAT: istat_next = istat_reg & ~apb_req.pwdata[IRQ_W-1:0];
                ADDR_IRQ_MASK: imask_next = apb_req.pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
        if (dc_wr) begin
            if (apb_req.pwdata[CMD_READ_BIT] && rd_pend_reg) begin
                // pending remote read request wins: command dropped
                istat_next[IRQ_ABORT] = 1'b1;
            end else if (!cmd_valid_reg || take) begin
                cmd_valid_next = 1'b1;
                cmd_read_next = apb_req.pwdata[CMD_READ_BIT];
                cmd_stop_next = apb_req.pwdata[CMD_STOP_BIT];
                cmd_byte_next = apb_req.pwdata[CMD_READ_BIT] ? 8'h00 : apb_req.pwdata[7:0];
            end
        end
        if (rx_evt) begin
            rx_byte_next = shift_reg;
            istat_next[IRQ_RX_DONE] = 1'b1;
        end
        if (stop_evt) begin
            istat_next[IRQ_STOP] = 1'b1;
        end
        if (rd_req_served) begin
            rd_pend_next = 1'b0;
        end
        if (rd_req_raise) begin
            rd_pend_next = 1'b1;
        end
        irq_next = |(istat_reg & imask_reg);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
            ss_h_reg <= SS_HIGH_RST;
            ss_l_reg <= SS_LOW_RST;
            fs_h_reg <= FS_HIGH_RST;
            ctrl_reg <= CTRL_RST;
            istat_reg <= '0;
            imask_reg <= '0;
            rd_pend_reg <= 1'b0;
            cmd_valid_reg <= 1'b0;
            cmd_read_reg <= 1'b0;
            cmd_stop_reg <= 1'b0;
            cmd_byte_reg <= 8'h00;
            rx_byte_reg <= 8'h00;
        end else if (ce) begin
            pready_reg <= pready_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
            ss_h_reg <= ss_h_next;
            ss_l_reg <= ss_l_next;
            fs_h_reg <= fs_h_next;
            ctrl_reg <= ctrl_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            rd_pend_reg <= rd_pend_next;
            cmd_valid_reg <= cmd_valid_next;
            cmd_read_reg <= cmd_read_next;
            cmd_stop_reg <= cmd_stop_next;
            cmd_byte_reg <= cmd_byte_next;
            rx_byte_reg <= rx_byte_next;
        end
    end

    // master byte engine: start, 8 data bits plus acknowledge, stop or stall
    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        cur_read_next = cur_read_reg;
        cur_stop_next = cur_stop_reg;
        sda_oe_next = sda_oe_reg;
        scl_oe_next = !tm_high;
        take = 1'b0;
        rx_evt = 1'b0;
        stop_evt = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                scl_oe_next = 1'b0;
                sda_oe_next = 1'b0;
                if (enabled && cmd_valid_reg) begin
                    take = 1'b1;
                    state_next = ST_START;
                    sda_oe_next = 1'b1;
                end
            end
            ST_START: begin
                if (tm_end) begin
                    state_next = ST_BIT;
                end
            end
            ST_BIT: begin
                // sda moves one cycle after scl has fallen, never with it
                if (!tm_high && scl_oe_reg) begin
                    if (bit_cnt_reg != LAST_BIT) begin
                        sda_oe_next = !cur_read_reg && !shift_reg[7];
                    end else begin
                        sda_oe_next = cur_read_reg && !cur_stop_reg;
                    end
                end
                if (tm_high && tm_end) begin
                    if (bit_cnt_reg != LAST_BIT) begin
                        shift_next = {shift_reg[6:0], sda_s2_reg};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else begin
                        rx_evt = cur_read_reg;
                        if (cur_stop_reg) begin
                            state_next = ST_STOP;
                        end else if (enabled && cmd_valid_reg) begin
                            take = 1'b1;
                        end else begin
                            state_next = ST_HOLD;
                        end
                    end
                end
            end
            ST_STOP: begin
                if (scl_oe_reg) begin
                    sda_oe_next = 1'b1;
                end
                if (tm_high && tm_end) begin
                    state_next = ST_IDLE;
                    sda_oe_next = 1'b0;
                    stop_evt = 1'b1;
                end
            end
            ST_HOLD: begin
                scl_oe_next = 1'b1;
                if (!enabled) begin
                    state_next = ST_IDLE;
                end else if (cmd_valid_reg) begin
                    take = 1'b1;
                    state_next = ST_BIT;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (take) begin
            bit_cnt_next = 4'h0;
            shift_next = cmd_byte_reg;
            cur_read_next = cmd_read_reg;
            cur_stop_next = cmd_stop_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            cur_read_reg <= 1'b0;
            cur_stop_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            cur_read_reg <= cur_read_next;
            cur_stop_reg <= cur_stop_next;
            scl_oe_reg <= scl_oe_next;
            sda_oe_reg <= sda_oe_next;
        end
    end

    // bus idle detector on synchronised lines
    always_comb begin
        idle_cnt_next = 16'h0000;
        if (scl_s2_reg && sda_s2_reg) begin
            // a lowered limit must not let the counter run on and wrap
            idle_cnt_next = (idle_cnt_reg >= idle_limit) ? idle_cnt_reg : idle_cnt_reg + 16'h0001;
        end
        bus_idle_next = (idle_cnt_reg >= idle_limit);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            idle_cnt_reg <= 16'h0000;
            bus_idle_reg <= 1'b0;
        end else if (ce) begin
            scl_s1_reg <= scl_in;
            scl_s2_reg <= scl_s1_reg;
            sda_s1_reg <= sda_in;
            sda_s2_reg <= sda_s1_reg;
            idle_cnt_reg <= idle_cnt_next;
            bus_idle_reg <= bus_idle_next;
        end
    end

    assign pready = pready_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign scl_oe = scl_oe_reg;
    assign sda_oe = sda_oe_reg;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rd_cmd_wr;
        ce && dc_wr && apb_req.pwdata[CMD_READ_BIT];
    endsequence

    sequence s_idle_edge;
        (ce && scl_s2_reg && sda_s2_reg && idle_cnt_reg == idle_limit - 16'h0001) ##1 (ce && $stable(ss_h_reg));
    endsequence

    abort_on_rdreq_a: assert property (s_rd_cmd_wr ##0 rd_pend_reg |=> istat_reg[IRQ_ABORT])
        else $error("read command after read request did not abort");
    cmd_discard_a: assert property (s_rd_cmd_wr ##0 rd_pend_reg |=> !(cmd_valid_reg && !$past(cmd_valid_reg)))
        else $error("colliding read command was queued");
    read_byte_zero_a: assert property (s_rd_cmd_wr ##0 (!rd_pend_reg && !cmd_valid_reg) |=> cmd_valid_reg && cmd_read_reg && cmd_byte_reg == 8'h00)
        else $error("read command kept its data byte");
    rx_readback_a: assert property (ce && rd_phase && !apb_req.pwrite && apb_req.paddr == ADDR_DATA_CMD |=> pready && prdata[7:0] == $past(rx_byte_reg))
        else $error("data register read did not return received byte");
    count_locked_a: assert property (ce && wr_acc && enabled && apb_req.paddr == ADDR_SS_HIGH |=> $stable(ss_h_reg))
        else $error("count changed while enabled");
    high_clamp_a: assert property (ce && wr_acc && !enabled && apb_req.paddr == ADDR_FS_HIGH && apb_req.pwdata[15:0] < HIGH_MIN |=> fs_h_reg == HIGH_MIN)
        else $error("fast high count not clamped to 6");
    low_clamp_a: assert property (ce && wr_acc && !enabled && apb_req.paddr == ADDR_SS_LOW && apb_req.pwdata[15:0] < LOW_MIN |=> ss_l_reg == LOW_MIN)
        else $error("standard low count not clamped to 8");
    idle_flag_a: assert property (s_idle_edge |=> bus_idle_reg)
        else $error("idle flag missing at high count plus 10");
    stop_after_a: assert property (ce && state_reg == ST_BIT && bit_cnt_reg == LAST_BIT && tm_high && tm_end && cur_stop_reg |=> state_reg == ST_STOP)
        else $error("stop bit did not lead to stop");
    hold_low_a: assert property (ce && state_reg == ST_HOLD && enabled ##1 ce |-> scl_oe_reg)
        else $error("clock not held low while stalled");

endmodule
`default_nettype wire

// [bench/idst_target_model.sv]
`timescale 1ns/100ps
`default_nettype none
module idst_target_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic reading,
    input wire logic [7:0] send_byte,
    output logic sda_oe,
    output logic [7:0] got_byte
);
    logic scl_q;
    logic sda_q;
    logic [3:0] bitn;
    logic [3:0] k;
    logic [7:0] sh;
    // bit position within the byte, 8 is the ack slot
    assign k = (bitn == 4'h9) ? 4'h0 : bitn;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bitn <= 4'h0;
            sda_oe <= 1'b0;
            got_byte <= 8'h00;
            sh <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (scl && scl_q && sda_q && !sda) begin
                bitn <= 4'h0;
            end else if (scl && !scl_q) begin
                bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
                // byte handed over at the ack slot, so the stop clock cannot shift it
                if (k < 4'h8) begin
                    sh <= {sh[6:0], sda};
                end else begin
                    got_byte <= sh;
                end
            end
            // act only after scl falls: ack writes, else drive read data msb first
            if (!scl && scl_q) begin
                if (k == 4'h8) begin
                    sda_oe <= !reading;
                end else if (k < 4'h8 && reading) begin
                    sda_oe <= !send_byte[3'h7 - k[2:0]];
                end else begin
                    sda_oe <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
    import idst_pkg::*;
    logic pclk, presetn, pready, pslverr, irq, scl_out, scl_oe, sda_out, sda_oe, sc_q;
    logic rd_req_raise, rd_req_served, reading, tgt_oe, scl, sda, e, ce;
    logic [31:0] prdata, rd;
    logic [7:0] send_byte, got_byte;
    idst_apb_req_t req;
    int err_total, compares, cyc, run, lo_len, hi_len;
    // open-drain wires with pull-ups
    assign scl = !scl_oe;
    assign sda = !(sda_oe || tgt_oe);
    idst_top idst_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(req), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .irq(irq), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .rd_req_raise(rd_req_raise),
        .rd_req_served(rd_req_served));
    idst_target_model idst_target_model_i (.pclk(pclk), .presetn(presetn), .scl(scl), .sda(sda),
        .reading(reading), .send_byte(send_byte), .sda_oe(tgt_oe), .got_byte(got_byte));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // run lengths of scl low and high phases
    always @(posedge pclk) begin
        if (scl_oe !== sc_q) begin
            if (sc_q) lo_len <= run;
            else hi_len <= run;
            run <= 1;
        end else begin
            run <= run + 1;
        end
        sc_q <= scl_oe;
    end
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        req <= '{1'b1, 1'b0, wr, addr, wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk(n < 50, 1);
        rd = prdata;
        e = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
        apb(1'b1, addr, wd);
    endtask
    task automatic rdchk(input logic [31:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(rd, exp);
    endtask
    task automatic irq_chk(input logic exp);
        @(posedge pclk);
        chk(irq, exp);
    endtask
    task automatic t_regs();
        rdchk(ADDR_SS_HIGH, 32'h91);
        rdchk(ADDR_SS_LOW, 32'hAB);
        rdchk(ADDR_FS_HIGH, 32'h1A);
        chk({30'h0, scl_out, sda_out}, 32'h0);
        apb(1'b0, 32'h5002_0330, 32'h0);
        chk(e, 1);
        wr(ADDR_SS_HIGH, 32'h5);
        rdchk(ADDR_SS_HIGH, 32'h6);
        wr(ADDR_FS_HIGH, 32'h0);
        rdchk(ADDR_FS_HIGH, 32'h6);
        wr(ADDR_SS_LOW, 32'h7);
        rdchk(ADDR_SS_LOW, 32'h8);
        wr(ADDR_SS_LOW, 32'h9);
        rdchk(ADDR_SS_LOW, 32'h9);
        wr(ADDR_SS_HIGH, 32'hABCD_FFF5);
        rdchk(ADDR_SS_HIGH, 32'hFFF5);
    endtask
    task automatic t_enabled();
        wr(ADDR_CTRL, 32'h3);
        wr(ADDR_SS_HIGH, 32'h40);
        wr(ADDR_SS_LOW, 32'h40);
        rdchk(ADDR_SS_HIGH, 32'hFFF5);
        rdchk(ADDR_SS_LOW, 32'h9);
        wr(ADDR_CTRL, 32'h2);
        wr(ADDR_SS_HIGH, 32'h14);
        wr(ADDR_SS_LOW, 32'hC);
        wr(ADDR_FS_HIGH, 32'h9);
        rdchk(ADDR_SS_HIGH, 32'h14);
    endtask
    // a read started while the clock enable is low must stall until it rises
    task automatic t_freeze();
        ce <= 1'b0;
        fork
            rdchk(ADDR_SS_LOW, 32'hC);
            begin
                repeat (3) @(posedge pclk);
                chk(pready, 0);
                ce <= 1'b1;
            end
        join
    endtask
    task automatic t_abort();
        @(posedge pclk);
        rd_req_raise <= 1'b1;
        @(posedge pclk);
        rd_req_raise <= 1'b0;
        wr(ADDR_IRQ_MASK, 32'h7);
        wr(ADDR_DATA_CMD, 32'h1FF);
        rdchk(ADDR_IRQ_STAT, 32'h1);
        irq_chk(1'b1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[3:1], 3'b100);
        wr(ADDR_IRQ_MASK, 32'h6);
        irq_chk(1'b0);
        wr(ADDR_IRQ_MASK, 32'h7);
        irq_chk(1'b1);
        wr(ADDR_IRQ_STAT, 32'h1);
        irq_chk(1'b0);
        wr(ADDR_DATA_CMD, 32'h2A5);
        rdchk(ADDR_IRQ_STAT, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[1], 1);
        @(posedge pclk);
        rd_req_served <= 1'b1;
        @(posedge pclk);
        rd_req_served <= 1'b0;
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        chk(n < 3000, 1);
    endtask
    task automatic t_frame(input logic [2:0] ctl, input logic [31:0] cmd, input int hexp, input logic [7:0] exp);
        int n;
        wr(ADDR_CTRL, {29'h0, ctl[2:1], 1'b0});
        wr(ADDR_DATA_CMD, cmd);
        wr(ADDR_CTRL, {29'h0, ctl});
        wait_irq();
        chk(hi_len, hexp);
        chk(lo_len, 12);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[0], 0);
        n = 0;
        while (rd[0] !== 1'b1 && n < 20) begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end
        chk(rd[0], 1);
        rdchk(ADDR_IRQ_STAT, cmd[8] ? 32'h6 : 32'h4);
        wr(ADDR_IRQ_STAT, 32'h7);
        if (cmd[8]) rdchk(ADDR_DATA_CMD, {24'h0, exp});
        else chk(got_byte, exp);
    endtask
    task automatic t_stall();
        int n;
        wr(ADDR_DATA_CMD, 32'h05A);
        n = 0;
        while (!(scl_oe === 1'b1 && run > 100) && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        chk(scl_oe, 1);
        wr(ADDR_DATA_CMD, 32'h2C3);
        wait_irq();
        chk(got_byte, 8'hC3);
    endtask
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        req = '0;
        rd_req_raise = 1'b0;
        rd_req_served = 1'b0;
        reading = 1'b0;
        send_byte = 8'hBC;
        cyc = 0;
        err_total = 0;
        compares = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_enabled();
        t_freeze();
        t_abort();
        t_frame(3'b011, 32'h2A5, 20, 8'hA5);
        reading <= 1'b1;
        t_frame(3'b011, 32'h3FF, 20, 8'hBC);
        reading <= 1'b0;
        t_frame(3'b101, 32'h23C, 9, 8'h3C);
        t_frame(3'b111, 32'h281, 9, 8'h81);
        t_stall();
        end_sim();
    end
endmodule
`default_nettype wire
